// ---- pkg/loopback_defines.vh ----
// register map, field positions and timing constants of the loopback self-test block
//
// What this block does
// - control bit 3 picks bus A when 0, bus B when 1.
// - writing 1 to control bit 2 launches the configured loopback test.
// - launch bit only sets while the diagnostic mode pin is already high.
// - launch bit clears itself when the test finishes.
// - read-only bit 1 sets when the test finishes without error.
// - read-only bit 0 sets on Manchester, parity, sync or data mismatch error.
// - pass and fail flags clear when the launch bit gets set.
// - transmit and receive words clear on master reset, survive software reset.
// - address 0x001F is transmit word in test mode, else alternate BIT word.
// - address 0x0002 is receive word in test mode, else current command.
// - test sends the transmit word and stores the word received back.
// - current command is meaningless after test mode until the next valid command.
// - bit 5 low is digital loopback off the bus, high drives the bus.
// - bit 4 high sends command sync, low sends data sync.
`ifndef LOOPBACK_DEFINES_VH
`define LOOPBACK_DEFINES_VH

// ==========================================================================
// register offsets and reset values
`define LB_REG_RX        16'h0002
`define LB_REG_TX        16'h001F
`define LB_REG_CTRL      16'h0028
`define LB_CTRL_RST      16'h0000
`define LB_WORD_RST      16'h0000

// ==========================================================================
// control register fields
`define LB_FAIL_BIT      0
`define LB_PASS_BIT      1
`define LB_LAUNCH_BIT    2
`define LB_BUS_BIT       3
`define LB_SYNC_BIT      4
`define LB_ANALOG_BIT    5

// ==========================================================================
// word framing: 6 sync half-bits, 16 data bits and parity as half-bit pairs
`define LB_WORD_HALVES   40
`define LB_SYNC_CMD      6'h38
`define LB_SYNC_DATA     6'h07

// ==========================================================================
// timing
`define LB_CLK_NS        8
`define LB_HALF_BIT_NS   500
`define LB_HALF_BIT_CYC  (`LB_HALF_BIT_NS / `LB_CLK_NS)
`define LB_HALF_MID_CYC  (`LB_HALF_BIT_CYC / 2)

`endif

// ---- core/loop_word_encoder.v ----
// Manchester encoder that serialises one loopback word as a half-bit stream
`timescale 1ns/1ns
`include "loopback_defines.vh"

module loop_word_encoder (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        abort,
  // request
  input  wire        start,
  input  wire [15:0] tx_word,
  input  wire        cmd_sync,
  // serial stream and timing
  output wire        line,
  output reg         active_r,
  output reg         mid_stb_r,
  output reg         done_r
);

  // integer forms first so each narrowing below is an explicit part-select
  localparam integer HALF_LAST_N = `LB_HALF_BIT_CYC - 1;
  localparam integer HALF_MID_N  = `LB_HALF_MID_CYC;
  localparam integer LAST_IDX_N  = `LB_WORD_HALVES - 1;
  localparam [6:0]   HALF_LAST   = HALF_LAST_N[6:0];
  localparam [6:0]   HALF_MID    = HALF_MID_N[6:0];
  localparam [5:0]   LAST_IDX    = LAST_IDX_N[5:0];

  reg  [39:0] pat_r;
  reg  [6:0]  cnt_r;
  reg  [5:0]  left_r;
  wire [33:0] body;
  wire        parity;

  // ==========================================================================
  // frame build: each data bit and the odd parity bit become a half-bit pair
  assign parity = ~^tx_word;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_bit
      assign body[2*g+3:2*g+2] = tx_word[g] ? 2'b10 : 2'b01;
    end
  endgenerate
  assign body[1:0] = parity ? 2'b10 : 2'b01;

  assign line = pat_r[39] & active_r;

  // ==========================================================================
  // shifter
  always @(posedge ref_clk) begin
    if (!rst_n || abort) begin
      pat_r     <= 40'h0000000000;
      cnt_r     <= 7'h00;
      left_r    <= 6'h00;
      active_r  <= 1'b0;
      mid_stb_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      done_r    <= 1'b0;
      mid_stb_r <= active_r && (cnt_r == HALF_MID);
      if (start && !active_r) begin
        pat_r    <= {(cmd_sync ? `LB_SYNC_CMD : `LB_SYNC_DATA), body};
        cnt_r    <= 7'h00;
        left_r   <= LAST_IDX;
        active_r <= 1'b1;
      end else if (active_r) begin
        if (cnt_r == HALF_LAST) begin
          cnt_r <= 7'h00;
          if (left_r == 6'h00) begin
            active_r <= 1'b0;
            done_r   <= 1'b1;
          end else begin
            left_r <= left_r - 6'h01;
            pat_r  <= {pat_r[38:0], 1'b0};
          end
        end else begin
          cnt_r <= cnt_r + 7'h01;
        end
      end
    end
  end

endmodule // loop_word_encoder

// ---- core/bus_loopback_self_test.v ----
// loopback self-test: registers, test sequencing, receive decoding and bus pin drive
`timescale 1ns/1ns
`include "loopback_defines.vh"

module bus_loopback_self_test (
  // clock and master reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // software reset pulse from the terminal
  input  wire        software_reset_bit,
  // diagnostic mode pin
  input  wire        diag_mode_pin,
  // host register port
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata_r,
  // terminal side
  input  wire [15:0] cur_cmd_word,
  input  wire        cmd_valid_stb,
  output reg  [15:0] alt_bit_word_r,
  output reg         cmd_meaningful_r,
  // bus transceiver pins
  input  wire        bus_a_rx,
  input  wire        bus_b_rx,
  output reg         bus_a_tx_r,
  output reg         bus_a_tx_oe_r,
  output reg         bus_b_tx_r,
  output reg         bus_b_tx_oe_r
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEND = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  localparam [15:0] CTRL_RST = `LB_CTRL_RST;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg         diag_s1_r;
  reg         diag_s2_r;
  reg         diag_d_r;
  reg         rxa_s1_r;
  reg         rxa_s2_r;
  reg         rxb_s1_r;
  reg         rxb_s2_r;
  reg         dig_s1_r;
  reg         dig_s2_r;
  reg  [15:0] tx_word_r;
  reg  [15:0] rx_word_r;
  reg  [39:0] rx_pat_r;
  reg         loop_bus_choice_r;
  reg         loop_sync_choice_r;
  reg         loop_analog_select_r;
  reg         loop_launch_r;
  reg         loop_passed_r;
  reg         loop_failed_r;
  reg         enc_start_r;
  wire        enc_line;
  wire        enc_active;
  wire        enc_mid;
  wire        enc_done;
  wire        wr_ctrl;
  wire        launch_req;
  wire        rx_sample;
  wire [16:0] pair_bad;
  wire [15:0] rx_data;
  wire        rx_par;
  wire [5:0]  exp_sync;
  wire        sync_err;
  wire        manch_err;
  wire        par_err;
  wire        data_err;
  wire        any_err;
  wire [15:0] ctrl_view;

  // ==========================================================================
  // input synchronisers: pins are asynchronous to ref_clk
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      diag_s1_r <= 1'b0;
      diag_s2_r <= 1'b0;
      diag_d_r  <= 1'b0;
      rxa_s1_r  <= 1'b0;
      rxa_s2_r  <= 1'b0;
      rxb_s1_r  <= 1'b0;
      rxb_s2_r  <= 1'b0;
      dig_s1_r  <= 1'b0;
      dig_s2_r  <= 1'b0;
    end else begin
      diag_s1_r <= diag_mode_pin;
      diag_s2_r <= diag_s1_r;
      diag_d_r  <= diag_s2_r;
      rxa_s1_r  <= bus_a_rx;
      rxa_s2_r  <= rxa_s1_r;
      rxb_s1_r  <= bus_b_rx;
      rxb_s2_r  <= rxb_s1_r;
      // digital path gets the same two-stage delay so both modes sample alike
      dig_s1_r  <= enc_line;
      dig_s2_r  <= dig_s1_r;
    end
  end

  // ==========================================================================
  // register decode
  assign wr_ctrl    = reg_wr && (reg_addr == `LB_REG_CTRL);
  assign launch_req = wr_ctrl && reg_wdata[`LB_LAUNCH_BIT] && diag_s2_r && (state_r == ST_IDLE);
  assign ctrl_view  = {10'h000, loop_analog_select_r, loop_sync_choice_r, loop_bus_choice_r,
                       loop_launch_r, loop_passed_r, loop_failed_r};

  // transmit word and alternate BIT word share one address, the pin picks which
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_word_r      <= `LB_WORD_RST;
      alt_bit_word_r <= `LB_WORD_RST;
    end else if (reg_wr && (reg_addr == `LB_REG_TX)) begin
      if (diag_s2_r)
        tx_word_r <= reg_wdata;
      else
        alt_bit_word_r <= reg_wdata;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `LB_REG_TX:   reg_rdata_r <= diag_s2_r ? tx_word_r : alt_bit_word_r;
        `LB_REG_RX:   reg_rdata_r <= diag_s2_r ? rx_word_r : cur_cmd_word;
        `LB_REG_CTRL: reg_rdata_r <= ctrl_view;
        default:      reg_rdata_r <= 16'h0000;
      endcase
    end
  end

  // leaving test mode invalidates the command view until a real command lands
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_meaningful_r <= 1'b0;
    end else if (cmd_valid_stb) begin
      cmd_meaningful_r <= 1'b1;
    end else if (diag_s2_r || diag_d_r) begin
      cmd_meaningful_r <= 1'b0;
    end
  end

  // ==========================================================================
  // sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (launch_req) state_nxt = ST_SEND;
      ST_SEND: if (enc_done)   state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n || software_reset_bit)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // control register; config is frozen while a test runs
  always @(posedge ref_clk) begin
    if (!rst_n || software_reset_bit) begin
      loop_bus_choice_r    <= CTRL_RST[`LB_BUS_BIT];
      loop_sync_choice_r   <= CTRL_RST[`LB_SYNC_BIT];
      loop_analog_select_r <= CTRL_RST[`LB_ANALOG_BIT];
      loop_launch_r        <= CTRL_RST[`LB_LAUNCH_BIT];
      loop_passed_r        <= CTRL_RST[`LB_PASS_BIT];
      loop_failed_r        <= CTRL_RST[`LB_FAIL_BIT];
      enc_start_r          <= 1'b0;
    end else begin
      enc_start_r <= launch_req;
      if (wr_ctrl && (state_r == ST_IDLE)) begin
        loop_bus_choice_r    <= reg_wdata[`LB_BUS_BIT];
        loop_sync_choice_r   <= reg_wdata[`LB_SYNC_BIT];
        loop_analog_select_r <= reg_wdata[`LB_ANALOG_BIT];
      end
      if (launch_req) begin
        loop_launch_r <= 1'b1;
        loop_passed_r <= 1'b0;
        loop_failed_r <= 1'b0;
      end else if (state_r == ST_DONE) begin
        loop_launch_r <= 1'b0;
        loop_passed_r <= ~any_err;
        loop_failed_r <= any_err;
      end
    end
  end

  // ==========================================================================
  // encoder
  loop_word_encoder u_enc (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .abort     (software_reset_bit),
    .start     (enc_start_r),
    .tx_word   (tx_word_r),
    .cmd_sync  (loop_sync_choice_r),
    .line      (enc_line),
    .active_r  (enc_active),
    .mid_stb_r (enc_mid),
    .done_r    (enc_done)
  );

  // bus drive only in analog mode and only on the chosen bus
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_a_tx_r    <= 1'b0;
      bus_a_tx_oe_r <= 1'b0;
      bus_b_tx_r    <= 1'b0;
      bus_b_tx_oe_r <= 1'b0;
    end else begin
      bus_a_tx_r    <= enc_line & ~loop_bus_choice_r;
      bus_a_tx_oe_r <= enc_active & loop_analog_select_r & ~loop_bus_choice_r;
      bus_b_tx_r    <= enc_line & loop_bus_choice_r;
      bus_b_tx_oe_r <= enc_active & loop_analog_select_r & loop_bus_choice_r;
    end
  end

  // ==========================================================================
  // receive path: sampling at mid half-bit tolerates skew up to a quarter bit
  assign rx_sample = loop_analog_select_r ? (loop_bus_choice_r ? rxb_s2_r : rxa_s2_r) : dig_s2_r;

  always @(posedge ref_clk) begin
    if (!rst_n || enc_start_r)
      rx_pat_r <= 40'h0000000000;
    else if (enc_mid)
      rx_pat_r <= {rx_pat_r[38:0], rx_sample};
  end

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_dec
      assign rx_data[g]  = rx_pat_r[2*g+3];
      assign pair_bad[g+1] = ~(rx_pat_r[2*g+3] ^ rx_pat_r[2*g+2]);
    end
  endgenerate
  assign pair_bad[0] = ~(rx_pat_r[1] ^ rx_pat_r[0]);
  assign rx_par      = rx_pat_r[1];

  assign exp_sync  = loop_sync_choice_r ? `LB_SYNC_CMD : `LB_SYNC_DATA;
  assign sync_err  = rx_pat_r[39:34] != exp_sync;
  assign manch_err = |pair_bad;
  assign par_err   = ~^{rx_data, rx_par};
  assign data_err  = rx_data != tx_word_r;
  assign any_err   = sync_err | manch_err | par_err | data_err;

  // received word is kept across software reset
  always @(posedge ref_clk) begin
    if (!rst_n)
      rx_word_r <= `LB_WORD_RST;
    else if (state_r == ST_DONE)
      rx_word_r <= rx_data;
  end

endmodule // bus_loopback_self_test

// ---- tb/loop_chk_chk.sv ----
// port checker for the loopback self-test block
`timescale 1ns/1ns
module loop_chk (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        software_reset_bit,
  input wire        diag_mode_pin,
  input wire [15:0] reg_addr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata_r,
  input wire        cmd_valid_stb,
  input wire        cmd_meaningful_r,
  input wire        bus_a_tx_r,
  input wire        bus_a_tx_oe_r,
  input wire        bus_b_tx_r,
  input wire        bus_b_tx_oe_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || software_reset_bit);
  wire unmapped = reg_addr != 16'h0002 && reg_addr != 16'h001F && reg_addr != 16'h0028;
  chk_one_bus: assert property (!(bus_a_tx_oe_r && bus_b_tx_oe_r))
    else $error("both buses driven at once");
  chk_reset_quiet: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_n |=> reg_rdata_r == 16'h0000 && !bus_a_tx_oe_r && !bus_b_tx_oe_r)
    else $error("outputs not cleared by master reset");
  chk_unmapped_zero: assert property (reg_rd && unmapped ##1 !reg_rd |=> reg_rdata_r == 16'h0000)
    else $error("unmapped read not zero");
  chk_read_hold: assert property (!reg_rd ##1 !reg_rd |=> $stable(reg_rdata_r))
    else $error("read data changed without a read");
  chk_cmd_valid: assert property ($rose(cmd_meaningful_r) |-> $past(cmd_valid_stb))
    else $error("command marked valid without a command");
  chk_test_cmd: assert property (diag_mode_pin [*4] |=> !cmd_meaningful_r)
    else $error("command marked valid in test mode");
  chk_half_a: assert property ($rose(bus_a_tx_r) |-> bus_a_tx_r [*8])
    else $error("bus A half-bit too short");
  chk_half_b: assert property ($rose(bus_b_tx_r) |-> bus_b_tx_r [*8])
    else $error("bus B half-bit too short");
endmodule // loop_chk

bind bus_loopback_self_test loop_chk chk_i (.ref_clk, .rst_n, .software_reset_bit, .diag_mode_pin,
  .reg_addr, .reg_rd, .reg_rdata_r, .cmd_valid_stb, .cmd_meaningful_r,
  .bus_a_tx_r, .bus_a_tx_oe_r, .bus_b_tx_r, .bus_b_tx_oe_r);

// ---- tb/bus_echo_model.sv ----
// bus transceiver model: echoes the driven line back after a short delay
`timescale 1ns/1ns
module bus_echo_model (
  // clock and fault control
  input  wire ref_clk,
  input  wire corrupt,
  // device transmit side
  input  wire tx_a,
  input  wire oe_a,
  input  wire tx_b,
  input  wire oe_b,
  // device receive side
  output wire rx_a,
  output wire rx_b
);
  reg [3:0] dly_a = 4'h0;
  reg [3:0] dly_b = 4'h0;
  reg       last_a = 1'b1;
  reg       last_b = 1'b1;
  // a released bus shows the inverse of its last value, never a stale copy
  assign rx_a = oe_a ? dly_a[3] : ~last_a;
  assign rx_b = oe_b ? dly_b[3] : ~last_b;
  always @(posedge ref_clk) begin
    dly_a <= {dly_a[2:0], tx_a ^ corrupt};
    dly_b <= {dly_b[2:0], tx_b ^ corrupt};
    if (oe_a) last_a <= dly_a[3];
    if (oe_b) last_b <= dly_b[3];
  end
endmodule // bus_echo_model

// ---- tb/bus_loopback_self_test_tb.sv ----
// self-checking bench for the loopback self-test block
`timescale 1ns/1ns
module bus_loopback_self_test_tb;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         software_reset_bit = 1'b0;
  reg         diag_mode_pin = 1'b0;
  reg  [15:0] reg_addr = 16'h0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg  [15:0] cur_cmd_word = 16'h5A5A;
  reg         cmd_valid_stb = 1'b0;
  reg         corrupt = 1'b0;
  wire [15:0] reg_rdata_r;
  wire [15:0] alt_bit_word_r;
  wire        cmd_meaningful_r, bus_a_rx, bus_b_rx, bus_a_tx_r, bus_a_tx_oe_r, bus_b_tx_r, bus_b_tx_oe_r;
  integer     bad_count = 0;
  integer     compares = 0;
  integer     cycles = 0;
  integer     i, n;
  reg  [15:0] v;
  reg  [47:0] rows [0:4];
  reg  [5:0]  c;

  always #4 ref_clk = ~ref_clk;

  bus_loopback_self_test uut (.ref_clk, .rst_n, .software_reset_bit, .diag_mode_pin, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata_r, .cur_cmd_word, .cmd_valid_stb, .alt_bit_word_r, .cmd_meaningful_r,
    .bus_a_rx, .bus_b_rx, .bus_a_tx_r, .bus_a_tx_oe_r, .bus_b_tx_r, .bus_b_tx_oe_r);
  bus_echo_model echo (.ref_clk, .corrupt, .tx_a(bus_a_tx_r), .oe_a(bus_a_tx_oe_r), .tx_b(bus_b_tx_r),
    .oe_b(bus_b_tx_oe_r), .rx_a(bus_a_rx), .rx_b(bus_b_rx));

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
    end
  endtask

  task rd(input [15:0] a);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(posedge ref_clk);
      #1 v = reg_rdata_r;
    end
  endtask

  task end_sim;
    begin
      if (bad_count == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end

  // ==========================================================================
  // rows: transmit word, control setting, expected flags
  initial begin
    rows[0] = {16'hA5C3, 16'h0000, 16'h0002};
    rows[1] = {16'hFFFF, 16'h0018, 16'h0002};
    rows[2] = {16'h0000, 16'h0030, 16'h0002};
    rows[3] = {16'h1234, 16'h0020, 16'h0001};
    rows[4] = {16'h8001, 16'h0028, 16'h0002};
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(16'h0028); chk(v, 16'h0000);
    rd(16'h0002); chk(v, 16'h5A5A);
    rd(16'h0003); chk(v, 16'h0000);
    // a valid command first, so that test mode has something to invalidate
    @(posedge ref_clk);
    cmd_valid_stb <= 1'b1;
    @(posedge ref_clk);
    cmd_valid_stb <= 1'b0;
    @(posedge ref_clk);
    #1 chk({15'h0, cmd_meaningful_r}, 16'h0001);
    // launch with the mode pin low must be refused
    wr(16'h0028, 16'h0004);
    rd(16'h0028); chk(v, 16'h0000);
    @(posedge ref_clk);
    diag_mode_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (i = 0; i < 5; i = i + 1) begin
      c = rows[i][21:16];
      corrupt <= rows[i][0];
      wr(16'h001F, rows[i][47:32]);
      rd(16'h001F); chk(v, rows[i][47:32]);
      wr(16'h0028, {10'h0, c});
      wr(16'h0028, {10'h0, c} | 16'h0004);
      rd(16'h0028); chk(v, {10'h0, c} | 16'h0004);
      repeat (10) @(posedge ref_clk);
      #1 chk({13'h0, c[5] & (c[3] ? bus_b_tx_r : bus_a_tx_r), bus_b_tx_oe_r, bus_a_tx_oe_r},
             {13'h0, c[5] & c[4], c[5] & c[3], c[5] & ~c[3]});
      n = 0;
      v = 16'h0004;
      while (v[2] && n < 1500) begin
        rd(16'h0028);
        n = n + 1;
      end
      chk(v, {10'h0, c} | rows[i][15:0]);
      if (rows[i][1]) begin
        rd(16'h0002); chk(v, rows[i][47:32]);
      end
    end
    // software reset keeps both loopback words
    @(posedge ref_clk);
    software_reset_bit <= 1'b1;
    @(posedge ref_clk);
    software_reset_bit <= 1'b0;
    rd(16'h0002); chk(v, 16'h8001);
    rd(16'h001F); chk(v, 16'h8001);
    // back to normal mode, host restores the alternate word
    @(posedge ref_clk);
    diag_mode_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk({15'h0, cmd_meaningful_r}, 16'h0000);
    wr(16'h001F, 16'hBEEF);
    rd(16'h001F); chk(v, 16'hBEEF);
    chk(alt_bit_word_r, 16'hBEEF);
    rd(16'h0002); chk(v, 16'h5A5A);
    @(posedge ref_clk);
    cmd_valid_stb <= 1'b1;
    @(posedge ref_clk);
    cmd_valid_stb <= 1'b0;
    @(posedge ref_clk);
    #1 chk({15'h0, cmd_meaningful_r}, 16'h0001);
    // master reset clears both loopback words
    @(posedge ref_clk);
    rst_n         <= 1'b0;
    diag_mode_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(16'h001F); chk(v, 16'h0000);
    rd(16'h0002); chk(v, 16'h0000);
    end_sim;
  end
endmodule // bus_loopback_self_test_tb
